// ==== core/ncd_alu.sv ====
// 4-bit binary adder with carry in and carry out.
// Purely combinational; caller decides what to do with the carry.
`timescale 1ns/1ps
module ncd_alu
(
   input wire logic [ncd_pkg::NIB_W-1:0] a_in,
   input wire logic [ncd_pkg::NIB_W-1:0] b_in,
   input wire logic carry_in,
   output logic [ncd_pkg::NIB_W-1:0] sum_out,
   output logic alu_carry_out
);
   import ncd_pkg::*;
   logic [NIB_W:0] total;
   always_comb
   begin
      total = {1'b0, a_in} + {1'b0, b_in} + {{NIB_W{1'b0}}, carry_in};
      sum_out = total[NIB_W-1:0];
      alu_carry_out = total[NIB_W];
   end
endmodule // ncd_alu

// ==== core/ncd_core.sv ====
// Nibble core datapath: work and aux registers, ALU, RAM pointer,
// data RAM with display region, program counter and return stack.
// Assumes an outside decoder presents one op per cycle with op_valid_in.
`timescale 1ns/1ps
// What this block does
// - 4-bit work nibble used with ALU, carry, RAM and I/O.
// - 4-bit aux nibble loads from and copies back to work nibble.
// - Table fetch loads 8-bit program word into aux and work pair.
// - ALU adds 4 bits in parallel: RAM, stored carry, work nibble.
// - ALU carry-out flags 4-bit overflow, separate from stored carry.
// - Add-with-carry writes ALU carry-out into stored carry.
// - Add-immediate-and-skip keeps carry; carry-out skips next op.
// - 8-bit RAM pointer selects the accessed data nibble.
// - Pointer splits into high and low nibbles, each loadable.
// - 8-bit pointer copy register holds a spare pointer value.
// - Pointer swap exchanges pointer and copy in one operation.
// - Display RAM drives segments automatically, 1/4 duty, 1/2 bias.
// - Each display nibble is one segment; bit n shows in common n.
// - Display RAM reads and writes exactly like ordinary RAM.
// - Row 8 column n drives segment 2n, row 9 drives 2n+1.
// - 170 nibbles of RAM, 42 of them display for segments 0-41.
// - 12-bit program counter: upper six page, lower six step.
// - Page changes only on transfers; step counts up per op.
// - Table fetch acts as a call using one return stack level.
// - Program memory pages hold 64 steps each.
module ncd_core
(
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic op_valid_in,
   input wire logic [3:0] op_in,
   input wire logic [ncd_pkg::PTR_W-1:0] operand_in,
   input wire logic [ncd_pkg::PC_W-1:0] jump_target_in,
   input wire logic [ncd_pkg::ROM_W-1:0] rom_data_in,
   input wire logic [ncd_pkg::NIB_W-1:0] io_data_in,
   output logic [ncd_pkg::PC_W-1:0] program_counter_out,
   output logic [ncd_pkg::NIB_W-1:0] work_nibble_out,
   output logic [ncd_pkg::NIB_W-1:0] aux_nibble_out,
   output logic stored_carry_out,
   output logic alu_carry_out,
   output logic skip_out,
   output logic busy_out,
   output logic [ncd_pkg::PTR_W-1:0] pointer_out,
   output logic [ncd_pkg::PTR_W-1:0] pointer_copy_out,
   output logic [ncd_pkg::NIB_W-1:0] mem_data_out,
   output logic [ncd_pkg::COM_N-1:0] common_lines_out,
   output logic frame_half_out,
   output logic [ncd_pkg::SEG_N-1:0] seg_on_out
);
   import ncd_pkg::*;
   // ****************
   // State
   // ****************
   logic [NIB_W-1:0] work_nibble_reg, work_nibble_next;
   logic [NIB_W-1:0] aux_reg, aux_next;
   logic carry_reg, carry_next;
   logic cy_reg, cy_next;
   logic skip_reg, skip_next;
   logic [NIB_W-1:0] pointer_high_reg, pointer_high_next;
   logic [NIB_W-1:0] pointer_low_reg, pointer_low_next;
   logic [PTR_W-1:0] pointer_copy_reg, pointer_copy_next;
   logic [PAGE_W-1:0] page_field_reg, page_field_next;
   logic [STEP_W-1:0] step_counter_reg, step_counter_next;
   logic [PC_W-1:0] return_stack_reg, return_stack_next;
   logic [NIB_W-1:0] mem_out_reg, mem_out_next;
   ncd_state_t state_reg, state_next;
   logic busy_reg, busy_next;
   // Full 8-bit space kept; cells outside the populated 170 simply exist
   logic [NIB_W-1:0] ram_mem [RAM_N];
   logic ram_we;
   logic [NIB_W-1:0] ram_rd;
   logic [PTR_W-1:0] ptr;
   logic [NIB_W-1:0] alu_b;
   logic alu_cin;
   logic [NIB_W-1:0] alu_sum;
   logic alu_cy;
   logic [SEG_N*4-1:0] disp_cells;
   logic [COM_N-1:0] com_act;
   logic lcd_half;
   logic [SEG_N-1:0] lcd_seg;
   logic [PC_W-1:0] pc_now;
   logic exec;
   always_comb
   begin
      ptr = {pointer_high_reg, pointer_low_reg};
      pc_now = {page_field_reg, step_counter_reg};
      ram_rd = ram_mem[ptr];
      // Skipped ops are consumed but have no effect
      exec = op_valid_in && !skip_reg && (state_reg == ST_RUN);
   end
   // ****************
   // ALU
   // ****************
   always_comb
   begin
      alu_b = ram_rd;
      alu_cin = carry_reg;
      if (op_in == OP_ADX)
      begin
         alu_b = operand_in[NIB_W-1:0];
         alu_cin = 1'b0;
      end
   end
   ncd_alu u_alu
   (
      .a_in(work_nibble_reg),
      .b_in(alu_b),
      .carry_in(alu_cin),
      .sum_out(alu_sum),
      .alu_carry_out(alu_cy)
   );
   // ****************
   // Datapath next state
   // ****************
   always_comb
   begin
      work_nibble_next = work_nibble_reg;
      aux_next = aux_reg;
      carry_next = carry_reg;
      cy_next = 1'b0;
      skip_next = skip_reg;
      pointer_high_next = pointer_high_reg;
      pointer_low_next = pointer_low_reg;
      pointer_copy_next = pointer_copy_reg;
      page_field_next = page_field_reg;
      step_counter_next = step_counter_reg;
      return_stack_next = return_stack_reg;
      state_next = state_reg;
      ram_we = 1'b0;
      mem_out_next = ram_rd;
      case (state_reg)
         ST_RUN:
         begin
            if (op_valid_in)
            begin
               // Step wraps inside the page; page untouched
               step_counter_next = step_counter_reg + 6'h01;
               skip_next = 1'b0;
            end
            if (exec)
            begin
               case (op_in)
                  OP_ADC:
                  begin
                     work_nibble_next = alu_sum;
                     cy_next = alu_cy;
                     carry_next = alu_cy;
                  end
                  OP_ADX:
                  begin
                     work_nibble_next = alu_sum;
                     cy_next = alu_cy;
                     skip_next = alu_cy;
                  end
                  OP_LD_MEM: work_nibble_next = ram_rd;
                  OP_ST_MEM: ram_we = 1'b1;
                  OP_A_TO_X: aux_next = work_nibble_reg;
                  OP_X_TO_A: work_nibble_next = aux_reg;
                  OP_TABLE:
                  begin
                     // Return to the op after the fetch
                     return_stack_next = {page_field_reg,
                        step_counter_reg + 6'h01};
                     page_field_next = work_nibble_reg[1:0] == 2'h0 ?
                        operand_in[7:2] : operand_in[7:2];
                     step_counter_next = {aux_reg[1:0], work_nibble_reg};
                     state_next = ST_FETCH;
                  end
                  OP_SWAP:
                  begin
                     pointer_copy_next = ptr;
                     pointer_high_next = pointer_copy_reg[7:4];
                     pointer_low_next = pointer_copy_reg[3:0];
                  end
                  OP_LD_HIGH: pointer_high_next = operand_in[3:0];
                  OP_LD_LOW: pointer_low_next = operand_in[3:0];
                  OP_JUMP:
                  begin
                     page_field_next = jump_target_in[11:6];
                     step_counter_next = jump_target_in[5:0];
                  end
                  OP_LD_IMM: work_nibble_next = operand_in[3:0];
                  OP_SET_C: carry_next = 1'b1;
                  OP_CLR_C: carry_next = 1'b0;
                  OP_IO_IN: work_nibble_next = io_data_in;
                  default: ;
               endcase
            end
         end
         ST_FETCH:
         begin
            // Program word at the table address lands in the pair
            aux_next = rom_data_in[7:4];
            work_nibble_next = rom_data_in[3:0];
            state_next = ST_RETURN;
         end
         ST_RETURN:
         begin
            page_field_next = return_stack_reg[11:6];
            step_counter_next = return_stack_reg[5:0];
            state_next = ST_RUN;
         end
         default: state_next = ST_RUN;
      endcase
      // Busy kept as its own flop so the pin needs no decode
      busy_next = (state_next != ST_RUN);
   end
   // ****************
   // Work, aux and carry registers
   // ****************
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         work_nibble_reg <= 4'h0;
         aux_reg <= 4'h0;
         carry_reg <= 1'b0;
         cy_reg <= 1'b0;
         skip_reg <= 1'b0;
      end
      else
      begin
         work_nibble_reg <= work_nibble_next;
         aux_reg <= aux_next;
         carry_reg <= carry_next;
         cy_reg <= cy_next;
         skip_reg <= skip_next;
      end
   end
   // ****************
   // Pointer registers
   // ****************
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         pointer_high_reg <= 4'h0;
         pointer_low_reg <= 4'h0;
         pointer_copy_reg <= 8'h00;
      end
      else
      begin
         pointer_high_reg <= pointer_high_next;
         pointer_low_reg <= pointer_low_next;
         pointer_copy_reg <= pointer_copy_next;
      end
   end
   // ****************
   // Sequencer registers
   // ****************
   // Page, step, stack and state move together so a fetch never
   // leaves the counter half restored
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         page_field_reg <= PC_RESET[11:6];
         step_counter_reg <= PC_RESET[5:0];
         return_stack_reg <= 12'h000;
         state_reg <= ST_RUN;
         busy_reg <= 1'b0;
      end
      else
      begin
         page_field_reg <= page_field_next;
         step_counter_reg <= step_counter_next;
         return_stack_reg <= return_stack_next;
         state_reg <= state_next;
         busy_reg <= busy_next;
      end
   end
   // ****************
   // RAM read-back register
   // ****************
   // One cycle late by design: shows the cell under the pointer
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         mem_out_reg <= 4'h0;
      end
      else
      begin
         mem_out_reg <= mem_out_next;
      end
   end
   // ****************
   // Data RAM
   // ****************
   // No reset on the array: RAM content is undefined after power-up
   always_ff @(posedge clk_in)
   begin
      if (ram_we)
         ram_mem[ptr] <= work_nibble_reg;
   end
   // ****************
   // Display map
   // ****************
   genvar g;
   generate
      for (g = 0; g < SEG_N; g++)
      begin : g_disp
         // Even segments in even rows, odd ones in the row below
         always_comb
            disp_cells[g*4 +: 4] =
               ram_mem[{DISP_ROW0 + 4'((g / 32) * 2 + (g % 2)),
                        4'((g % 32) / 2)}];
      end
   endgenerate
   ncd_lcd u_lcd
   (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .cells_in(disp_cells),
      .phase_out(),
      .frame_half_out(lcd_half),
      .com_active_out(com_act),
      .seg_on_out(lcd_seg)
   );
   always_comb
   begin
      program_counter_out = pc_now;
      work_nibble_out = work_nibble_reg;
      aux_nibble_out = aux_reg;
      stored_carry_out = carry_reg;
      alu_carry_out = cy_reg;
      skip_out = skip_reg;
      busy_out = busy_reg;
      pointer_out = ptr;
      pointer_copy_out = pointer_copy_reg;
      mem_data_out = mem_out_reg;
      common_lines_out = com_act;
      frame_half_out = lcd_half;
      seg_on_out = lcd_seg;
   end
endmodule // ncd_core

// ==== core/ncd_lcd.sv ====
// Segment drive from display cells: 1/4 duty, 1/2 bias levels.
// Assumes cell bits arrive flattened, segment s at [4s+3:4s].
`timescale 1ns/1ps
module ncd_lcd
(
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic [ncd_pkg::SEG_N*4-1:0] cells_in,
   output logic [1:0] phase_out,
   output logic frame_half_out,
   output logic [ncd_pkg::COM_N-1:0] com_active_out,
   output logic [ncd_pkg::SEG_N-1:0] seg_on_out
);
   import ncd_pkg::*;
   logic [3:0] div_reg, div_next;
   logic [1:0] phase_reg, phase_next;
   logic half_reg, half_next;
   logic [SEG_N-1:0] seg_reg, seg_next;
   logic [COM_N-1:0] com_reg, com_next;
   // ****************
   // Phase sequencing
   // ****************
   always_comb
   begin
      div_next = div_reg + 4'h1;
      phase_next = phase_reg;
      half_next = half_reg;
      if (div_reg == PHASE_LAST)
      begin
         phase_next = phase_reg + 2'h1;
         // Frame polarity flips each full scan to keep LCD DC-free
         if (phase_reg == 2'h3)
            half_next = ~half_reg;
      end
      // Commons registered beside segments so both switch together
      com_next = 4'h1 << phase_next;
   end
   // ****************
   // Segment select
   // ****************
   genvar s;
   generate
      for (s = 0; s < SEG_N; s++)
      begin : g_seg
         always_comb
            seg_next[s] = cells_in[s*4 + phase_next];
      end
   endgenerate
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         div_reg <= 4'h0;
         phase_reg <= 2'h0;
         half_reg <= 1'b0;
         seg_reg <= '0;
         com_reg <= 4'h1;
      end
      else
      begin
         div_reg <= div_next;
         phase_reg <= phase_next;
         half_reg <= half_next;
         seg_reg <= seg_next;
         com_reg <= com_next;
      end
   end
   always_comb
   begin
      phase_out = phase_reg;
      frame_half_out = half_reg;
      com_active_out = com_reg;
      seg_on_out = seg_reg;
   end
endmodule // ncd_lcd

// ==== core/ncd_pkg.sv ====
// Package for the nibble core datapath: widths, map constants, ops.
// Assumes a single 100 MHz clock domain.
package ncd_pkg;
   localparam int NIB_W = 4;
   localparam int PTR_W = 8;
   localparam int PC_W = 12;
   localparam int PAGE_W = 6;
   localparam int STEP_W = 6;
   localparam int ROM_W = 8;
   localparam int SEG_N = 42;
   localparam int COM_N = 4;
   localparam int RAM_N = 256;
   localparam int STACK_N = 4;
   localparam logic [3:0] DISP_ROW0 = 4'h8;
   localparam logic [3:0] DISP_ROW_LAST = 4'hB;
   localparam logic [3:0] DISP_COL_SHORT = 4'h4;
   localparam logic [5:0] STEP_LAST = 6'h3F;
   localparam logic [11:0] PC_RESET = 12'h000;
   // One common phase per this many clocks
   localparam int PHASE_CYC = 16;
   localparam logic [3:0] PHASE_LAST = 4'hF;
   // Datapath operations
   localparam logic [3:0] OP_NOP = 4'h0;
   localparam logic [3:0] OP_ADC = 4'h1;
   localparam logic [3:0] OP_ADX = 4'h2;
   localparam logic [3:0] OP_LD_MEM = 4'h3;
   localparam logic [3:0] OP_ST_MEM = 4'h4;
   localparam logic [3:0] OP_A_TO_X = 4'h5;
   localparam logic [3:0] OP_X_TO_A = 4'h6;
   localparam logic [3:0] OP_TABLE = 4'h7;
   localparam logic [3:0] OP_SWAP = 4'h8;
   localparam logic [3:0] OP_LD_HIGH = 4'h9;
   localparam logic [3:0] OP_LD_LOW = 4'hA;
   localparam logic [3:0] OP_JUMP = 4'hB;
   localparam logic [3:0] OP_LD_IMM = 4'hC;
   localparam logic [3:0] OP_SET_C = 4'hD;
   localparam logic [3:0] OP_CLR_C = 4'hE;
   localparam logic [3:0] OP_IO_IN = 4'hF;
   typedef enum logic [2:0] {
      ST_RUN = 3'b001,
      ST_FETCH = 3'b010,
      ST_RETURN = 3'b100
   } ncd_state_t;
endpackage

// ==== verif/ncd_core_properties.sv ====
// Concurrent checks on the ports of the nibble core datapath.
// Assumes one clock, synchronous active-high reset, bound below.
`timescale 1ns/1ps
module ncd_core_properties
(
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic op_valid_in,
   input wire logic [3:0] op_in,
   input wire logic [ncd_pkg::PTR_W-1:0] operand_in,
   input wire logic [ncd_pkg::PC_W-1:0] program_counter_out,
   input wire logic [ncd_pkg::NIB_W-1:0] work_nibble_out,
   input wire logic [ncd_pkg::NIB_W-1:0] aux_nibble_out,
   input wire logic stored_carry_out,
   input wire logic alu_carry_out,
   input wire logic skip_out,
   input wire logic busy_out,
   input wire logic [ncd_pkg::PTR_W-1:0] pointer_out,
   input wire logic [ncd_pkg::PTR_W-1:0] pointer_copy_out,
   input wire logic [ncd_pkg::NIB_W-1:0] mem_data_out,
   input wire logic [ncd_pkg::COM_N-1:0] common_lines_out
);
   import ncd_pkg::*;
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);
   logic go;
   logic [3:0] imm;
   logic [3:0] com_rot;
   logic [11:0] pc_inc;
   assign go = op_valid_in && !busy_out && !skip_out;
   assign imm = operand_in[3:0];
   assign com_rot = {common_lines_out[2:0], common_lines_out[3]};
   // Step field wraps inside its page
   assign pc_inc = {program_counter_out[11:6],
      program_counter_out[5:0] + 6'h01};
   // ***************************************************
   // Properties
   // ***************************************************
   sequence fetch_busy_s;
      busy_out ##1 busy_out;
   endsequence
   sequence fetch_done_s;
      !busy_out && program_counter_out == $past(pc_inc, 3);
   endsequence
   swap_exchange_a: assert property (
      go && op_in == OP_SWAP |=> pointer_out == $past(pointer_copy_out)
      && pointer_copy_out == $past(pointer_out))
      else $error("pointer swap did not exchange");
   add_carry_a: assert property (
      go && op_in == OP_ADC && $stable(pointer_out) && !$past(op_valid_in)
      |=> alu_carry_out == stored_carry_out
      && {stored_carry_out, work_nibble_out} == 5'($past(work_nibble_out))
      + 5'($past(mem_data_out)) + 5'($past(stored_carry_out)))
      else $error("add with carry result wrong");
   add_skip_a: assert property (
      go && op_in == OP_ADX |=> stored_carry_out == $past(stored_carry_out)
      && skip_out == alu_carry_out && {alu_carry_out, work_nibble_out}
      == 5'($past(work_nibble_out)) + 5'($past(imm)))
      else $error("add and skip result wrong");
   table_call_a: assert property (
      go && op_in == OP_TABLE |=> fetch_busy_s ##1 fetch_done_s)
      else $error("table fetch sequence wrong");
   step_count_a: assert property (
      op_valid_in && !busy_out
      && (skip_out || (op_in != OP_JUMP && op_in != OP_TABLE))
      |=> program_counter_out == $past(pc_inc))
      else $error("step counter did not advance");
   idle_pc_a: assert property (
      !op_valid_in && !busy_out |=> $stable(program_counter_out))
      else $error("program counter moved while idle");
   aux_load_a: assert property (
      go && op_in == OP_A_TO_X |=> aux_nibble_out == $past(work_nibble_out))
      else $error("aux nibble not loaded");
   common_onehot_a: assert property (
      $onehot(common_lines_out))
      else $error("common lines not one-hot");
   common_order_a: assert property (
      $changed(common_lines_out) |-> common_lines_out == $past(com_rot))
      else $error("common lines out of order");
   phase_hold_a: assert property (
      $changed(common_lines_out) |=> $stable(common_lines_out) [*8])
      else $error("common phase too short");
endmodule // ncd_core_properties

bind ncd_core ncd_core_properties chk (.*);

// ==== verif/ncd_core_tb.sv ====
// Self-checking bench for the nibble core datapath.
// Drives ncd_core ports directly; the checker is bound on its own.
`timescale 1ns/1ps
module ncd_core_tb;
   import ncd_pkg::*;
   logic clk_in, rst_in, op_valid_in, c_flag, cy, skip, busy, half;
   logic [3:0] op_in, io_data_in, work, aux, mem, com;
   logic [7:0] operand_in, rom_data_in, ptr, ptr_copy;
   logic [11:0] jump_target_in, pc, p;
   logic [41:0] seg;
   logic [7:0] addrs [4] = '{8'h80, 8'h90, 8'hB0, 8'hB4};
   logic [3:0] vals [4] = '{4'h5, 4'hA, 4'h3, 4'hC};
   int failures, checks_done;
   ncd_core dut
   (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .op_valid_in(op_valid_in),
      .op_in(op_in),
      .operand_in(operand_in),
      .jump_target_in(jump_target_in),
      .rom_data_in(rom_data_in),
      .io_data_in(io_data_in),
      .program_counter_out(pc),
      .work_nibble_out(work),
      .aux_nibble_out(aux),
      .stored_carry_out(c_flag),
      .alu_carry_out(cy),
      .skip_out(skip),
      .busy_out(busy),
      .pointer_out(ptr),
      .pointer_copy_out(ptr_copy),
      .mem_data_out(mem),
      .common_lines_out(com),
      .frame_half_out(half),
      .seg_on_out(seg)
   );
   initial
   begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end
   // ***************************************************
   // Shared tasks
   // ***************************************************
   task automatic chk(input logic [47:0] got, input logic [47:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         failures++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic stop_test;
      $display("Checks %0d, mismatches %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic tick;
      @(posedge clk_in);
      #1;
   endtask
   // One op, taken at the second edge; results settle on return
   task automatic issue(input logic [3:0] o, input logic [7:0] d);
      tick();
      op_valid_in = 1'b1;
      op_in = o;
      operand_in = d;
      tick();
      op_valid_in = 1'b0;
   endtask
   task automatic wait_com(input logic [3:0] want);
      int n;
      n = 0;
      while (com !== want && n < 100)
      begin
         tick();
         n++;
      end
      if (n == 100)
      begin
         failures++;
         stop_test();
      end
   endtask
   // ***************************************************
   // Scenarios
   // ***************************************************
   task automatic t_regs;
      issue(OP_LD_IMM, 8'h55);
      issue(OP_A_TO_X, 8'h00);
      chk(aux, 4'h5);
      io_data_in = 4'hC;
      issue(OP_IO_IN, 8'h00);
      chk(work, 4'hC);
      issue(OP_X_TO_A, 8'h00);
      chk(work, 4'h5);
   endtask
   task automatic t_ptr;
      issue(OP_LD_HIGH, 8'h33);
      issue(OP_LD_LOW, 8'h77);
      chk(ptr, 8'h37);
      issue(OP_SWAP, 8'h00);
      chk({ptr, ptr_copy}, 16'h0037);
      issue(OP_LD_LOW, 8'h22);
      issue(OP_SWAP, 8'h00);
      chk({ptr, ptr_copy}, 16'h3702);
   endtask
   task automatic t_add;
      issue(OP_LD_IMM, 8'h99);
      issue(OP_ST_MEM, 8'h00);
      issue(OP_LD_IMM, 8'h00);
      issue(OP_LD_MEM, 8'h00);
      chk(work, 4'h9);
      issue(OP_CLR_C, 8'h00);
      issue(OP_LD_IMM, 8'h88);
      issue(OP_ADC, 8'h00);
      chk({cy, c_flag, work}, 6'h31);
      tick();
      chk(cy, 1'b0);
      issue(OP_ADC, 8'h00);
      chk({cy, c_flag, work}, 6'h0B);
      issue(OP_SET_C, 8'h00);
      issue(OP_LD_IMM, 8'hEE);
      issue(OP_ADX, 8'h33);
      chk({skip, c_flag, work}, 6'h31);
      p = pc + 12'h001;
      issue(OP_LD_IMM, 8'h55);
      chk({skip, work, pc}, {1'b0, 4'h1, p});
      issue(OP_CLR_C, 8'h00);
      issue(OP_ADX, 8'h88);
      chk({skip, c_flag, work}, 6'h09);
      issue(OP_LD_IMM, 8'hEE);
      issue(OP_ADX, 8'h22);
      chk({skip, c_flag, work}, 6'h20);
      issue(OP_NOP, 8'h00);
   endtask
   task automatic t_table;
      jump_target_in = 12'h2C5;
      issue(OP_JUMP, 8'h00);
      chk(pc, 12'h2C5);
      issue(OP_LD_IMM, 8'h22);
      issue(OP_A_TO_X, 8'h00);
      issue(OP_LD_IMM, 8'h99);
      // Fetch driven by hand so valid stays up into the busy cycle
      tick();
      op_valid_in = 1'b1;
      op_in = OP_TABLE;
      operand_in = 8'hB4;
      rom_data_in = 8'hA6;
      tick();
      chk({busy, pc}, 13'h1B69);
      // Op offered while busy must be dropped
      op_in = OP_LD_IMM;
      operand_in = 8'hFF;
      tick();
      op_valid_in = 1'b0;
      tick();
      chk({busy, aux, work, pc}, 21'h0A62C9);
   endtask
   task automatic t_wrap;
      jump_target_in = 12'h7FE;
      issue(OP_JUMP, 8'h00);
      issue(OP_NOP, 8'h00);
      chk(pc, 12'h7FF);
      issue(OP_NOP, 8'h00);
      chk(pc, 12'h7C0);
   endtask
   task automatic t_lcd;
      logic h;
      for (int i = 0; i < 4; i++)
      begin
         issue(OP_LD_HIGH, {2{addrs[i][7:4]}});
         issue(OP_LD_LOW, {2{addrs[i][3:0]}});
         issue(OP_LD_IMM, {2{vals[i]}});
         issue(OP_ST_MEM, 8'h00);
         issue(OP_LD_IMM, 8'h00);
         issue(OP_LD_MEM, 8'h00);
         chk(work, vals[i]);
      end
      for (int n = 0; n < 4; n++)
      begin
         // Segments and commons switch at the same edge
         wait_com(4'h1 << n);
         chk({seg[41], seg[33], seg[1], seg[0]}, {vals[3][n], vals[2][n],
            vals[1][n], vals[0][n]});
      end
      // Polarity flips once per full scan of the commons
      h = half;
      wait_com(4'h1);
      chk(half, {~h});
   endtask
   initial
   begin
      rst_in = 1'b1;
      op_valid_in = 1'b0;
      op_in = OP_NOP;
      operand_in = 8'h00;
      jump_target_in = 12'h000;
      rom_data_in = 8'h00;
      io_data_in = 4'h0;
      failures = 0;
      checks_done = 0;
      repeat (20) @(posedge clk_in);
      #1;
      rst_in = 1'b0;
      chk({pc, work, ptr, com}, 28'h0000001);
      t_regs();
      t_ptr();
      t_add();
      t_table();
      t_wrap();
      t_lcd();
      stop_test();
   end
   initial
   begin
      #200000;
      failures++;
      stop_test();
   end
endmodule // ncd_core_tb
